//--- dmasa_channel.sv
// Short-address DMA channel with full-address options and an AXI4-Lite register file.
// Assumes one clock; the bus arbiter grants with busGrant and the bus finishes an item with xferDone.
`timescale 1ns/1ps
module dmasa_channel
(
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // AXI4-Lite register slave
   input  wire logic [dmasa_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [dmasa_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   // Request sources
   input  wire logic [3:0]                     timerMatchA,
   input  wire logic                           serialTxEmpty,
   input  wire logic                           serialRxFull,
   input  wire logic                           extReqN,
   // System bus side
   output logic                                busReq,
   input  wire logic                           busGrant,
   input  wire logic                           higherMasterReq,
   output logic                                xferValid,
   output logic [dmasa_pkg::ADDR_W-1:0]        xferSrc,
   output logic [dmasa_pkg::ADDR_W-1:0]        xferDst,
   output logic                                xferWord,
   input  wire logic                           xferDone,
   // Completion interrupt
   output logic                                cpuIrq
);
   import dmasa_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [ADDR_W-1:0] memAddr_reg;
   logic [ADDR_W-1:0] dstAddr_reg;
   logic [ADDR_W-1:0] memStart_reg;
   logic [ADDR_W-1:0] dstStart_reg;
   logic [7:0]        ioLow_reg;
   logic [CNT_W-1:0]  count_reg;
   logic [7:0]        blkSize_reg;
   logic [7:0]        blkLeft_reg;
   logic              enable_reg;
   logic              irqEn_reg;
   logic              wordSize_reg;
   logic              memDec_reg;
   logic              blkSrcArea_reg;
   logic [2:0]        mode_reg;
   logic [2:0]        srcSel_reg;
   logic [1:0]        dstStep_reg;
   logic              done_reg;
   logic              pending_reg;
   logic              extPrev_reg;
   logic              rxDir_reg;
   dmasa_state_t      state_reg;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshake state
   logic              awOpen_reg;
   logic              wOpen_reg;
   logic              arOpen_reg;
   logic [AXI_AW-1:0] awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;
   logic              bValid_reg;
   logic [1:0]        bResp_reg;
   logic              rValid_reg;
   logic [1:0]        rResp_reg;
   logic [31:0]       rData_reg;

   wire awTake  = s_axi_awvalid && awOpen_reg;
   wire wTake   = s_axi_wvalid && wOpen_reg;
   wire arTake  = s_axi_arvalid && arOpen_reg;
   wire haveAw  = !awOpen_reg;
   wire haveW   = !wOpen_reg;
   wire wrFire  = haveAw && haveW && !bValid_reg;
   wire bDone   = bValid_reg && s_axi_bready;
   wire rDone   = rValid_reg && s_axi_rready;

   // Write decode
   wire wrMem   = wrFire && awAddr_reg == OFS_MEMADDR;
   wire wrIo    = wrFire && awAddr_reg == OFS_IOADDR;
   wire wrCnt   = wrFire && awAddr_reg == OFS_COUNT;
   wire wrCtl   = wrFire && awAddr_reg == OFS_CTRL;
   wire wrSta   = wrFire && awAddr_reg == OFS_STATUS;
   wire wrDst   = wrFire && awAddr_reg == OFS_DSTADDR;
   wire wrBlk   = wrFire && awAddr_reg == OFS_BLKSIZE;
   wire wrHit   = wrMem || wrIo || wrCnt || wrCtl || wrSta || wrDst || wrBlk;
   wire [31:0] wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

   ////////////////////////////////////////////////////////////////////////////
   // Request selection
   logic extLevel;
   dmasa_sync u_extSync
   (
      .clk      (clk),
      .rst      (rst),
      .pinIn    (extReqN),
      .levelOut (extLevel)
   );

   wire [7:0] srcVec = {!extLevel, extPrev_reg && !extLevel, serialRxFull, serialTxEmpty, timerMatchA};
   wire isAuto   = mode_reg == MODE_BURST || mode_reg == MODE_STEAL;
   wire isShort  = mode_reg == MODE_IO || mode_reg == MODE_IDLE;
   wire isBlock  = mode_reg == MODE_BLOCK;
   wire extOnly  = mode_reg == MODE_EXT;
   // Full-address external runs take only the pin; block runs take timer or pin
   wire srcOk    = isShort || (extOnly && (srcSel_reg == SRC_EXTEDGE || srcSel_reg == SRC_EXTLVL))
                   || (isBlock && (srcSel_reg < SRC_TXEMPTY || srcSel_reg == SRC_EXTEDGE));
   wire reqEvent = enable_reg && srcOk && srcVec[srcSel_reg];
   wire startNow = enable_reg && (isAuto || pending_reg) && state_reg == ST_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // Address and count arithmetic
   wire [ADDR_W-1:0] stepAmt  = wordSize_reg ? 24'h000002 : 24'h000001;
   wire [ADDR_W-1:0] memStep  = memDec_reg ? memAddr_reg - stepAmt : memAddr_reg + stepAmt;
   wire [ADDR_W-1:0] dstStepV = dstStep_reg == STEP_INC ? dstAddr_reg + stepAmt
                              : dstStep_reg == STEP_DEC ? dstAddr_reg - stepAmt : dstAddr_reg;
   wire [ADDR_W-1:0] ioFull   = {IO_HIGH_ONES, ioLow_reg};
   wire [CNT_W-1:0]  cntDec   = count_reg - CNT_ONE;
   wire itemDone  = state_reg == ST_XFER && xferDone;
   wire blockEnd  = isBlock && blkLeft_reg == BLK_ONE;
   // A count of one before the step is the last; zero wraps to 65,535, so 65,536 items run
   wire lastItem  = count_reg == CNT_ONE && (!isBlock || blockEnd);
   wire finish    = itemDone && lastItem;
   wire irqCause  = mode_reg == MODE_IDLE || irqEn_reg;
   // Burst keeps the bus for back-to-back items while no higher master asks
   wire keepBus   = (mode_reg == MODE_BURST || (isBlock && !blockEnd)) && !higherMasterReq;

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg   <= ST_IDLE;
         busReq      <= 1'b0;
         xferValid   <= 1'b0;
         xferSrc     <= '0;
         xferDst     <= '0;
         xferWord    <= 1'b0;
         pending_reg <= 1'b0;
         extPrev_reg <= 1'b1;
         rxDir_reg   <= 1'b0;
      end
      else
      begin
         extPrev_reg <= extLevel;
         // A request landing while the previous is consumed is kept
         pending_reg <= reqEvent || (pending_reg && !startNow && enable_reg);
         unique case (state_reg)
            ST_IDLE:
            begin
               if (startNow)
               begin
                  busReq    <= 1'b1;
                  rxDir_reg <= isShort && srcSel_reg == SRC_RXFULL;
                  state_reg <= ST_REQ;
               end
            end
            ST_REQ:
            begin
               if (!enable_reg)
               begin
                  busReq    <= 1'b0;
                  state_reg <= ST_IDLE;
               end
               else if (busGrant)
               begin
                  xferValid <= 1'b1;
                  xferWord  <= wordSize_reg;
                  xferSrc   <= isShort ? (rxDir_reg ? ioFull : memAddr_reg) : memAddr_reg;
                  xferDst   <= isShort ? (rxDir_reg ? memAddr_reg : ioFull) : dstAddr_reg;
                  state_reg <= ST_XFER;
               end
            end
            ST_XFER:
            begin
               if (xferDone)
               begin
                  xferValid <= 1'b0;
                  if (!finish && keepBus)
                  begin
                     state_reg <= ST_REQ;
                  end
                  else
                  begin
                     busReq    <= 1'b0;
                     state_reg <= ST_GAP;
                  end
               end
            end
            ST_GAP:
            begin
               // One idle cycle so another master can take the bus
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         memAddr_reg    <= '0;
         dstAddr_reg    <= '0;
         memStart_reg   <= '0;
         dstStart_reg   <= '0;
         ioLow_reg      <= '0;
         count_reg      <= '0;
         blkSize_reg    <= BLK_ONE;
         blkLeft_reg    <= BLK_ONE;
         enable_reg     <= 1'b0;
         irqEn_reg      <= 1'b0;
         wordSize_reg   <= 1'b0;
         memDec_reg     <= 1'b0;
         blkSrcArea_reg <= 1'b0;
         mode_reg       <= MODE_IO;
         srcSel_reg     <= '0;
         dstStep_reg    <= STEP_FIX;
         done_reg       <= 1'b0;
         cpuIrq         <= 1'b0;
      end
      else
      begin
         if (itemDone)
         begin
            // Idle mode and short-mode I/O side never move
            if (mode_reg != MODE_IDLE)
               memAddr_reg <= memStep;
            if (!isShort)
               dstAddr_reg <= dstStepV;
            if (isBlock)
            begin
               blkLeft_reg <= blockEnd ? blkSize_reg : blkLeft_reg - BLK_ONE;
               if (blockEnd && blkSrcArea_reg)
                  memAddr_reg <= memStart_reg;
               if (blockEnd && !blkSrcArea_reg)
                  dstAddr_reg <= dstStart_reg;
            end
            if (!isBlock || blockEnd)
               count_reg <= cntDec;
            if (lastItem)
               enable_reg <= 1'b0;
         end
         // Software writes take precedence over stepping in the same cycle
         if (wrMem)
         begin
            memAddr_reg  <= wData_reg[ADDR_W-1:0];
            memStart_reg <= wData_reg[ADDR_W-1:0];
         end
         if (wrDst)
         begin
            dstAddr_reg  <= wData_reg[ADDR_W-1:0];
            dstStart_reg <= wData_reg[ADDR_W-1:0];
         end
         if (wrIo && wStrb_reg[0])
            ioLow_reg <= wData_reg[7:0];
         if (wrCnt)
            count_reg <= (count_reg & ~wMask[CNT_W-1:0]) | (wData_reg[CNT_W-1:0] & wMask[CNT_W-1:0]);
         if (wrBlk && wStrb_reg[0])
         begin
            blkSize_reg <= wData_reg[7:0];
            blkLeft_reg <= wData_reg[7:0];
         end
         if (wrCtl && wStrb_reg[0])
         begin
            enable_reg     <= wData_reg[CTL_EN];
            irqEn_reg      <= wData_reg[CTL_IRQEN];
            wordSize_reg   <= wData_reg[CTL_WORD];
            memDec_reg     <= wData_reg[CTL_DEC];
            blkSrcArea_reg <= wData_reg[CTL_BLKSRC];
         end
         if (wrCtl && wStrb_reg[1])
            mode_reg <= wData_reg[CTL_MODE+:3];
         if (wrCtl && wStrb_reg[2])
         begin
            srcSel_reg  <= wData_reg[CTL_SRC+:3];
            dstStep_reg <= wData_reg[CTL_DSTST+:2];
         end
         // Completion flag: hardware set wins over a write-one clear
         done_reg <= (finish && irqCause) || (done_reg && !(wrSta && wStrb_reg[0] && wData_reg[STA_DONE]));
         cpuIrq   <= (finish && irqCause) || (done_reg && !(wrSta && wStrb_reg[0] && wData_reg[STA_DONE]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   wire [31:0] ctlRead = {14'h0, dstStep_reg, 1'b0, srcSel_reg, 1'b0, mode_reg,
                          3'h0, blkSrcArea_reg, memDec_reg, wordSize_reg, irqEn_reg, enable_reg};
   wire [31:0] staRead = {30'h0, state_reg != ST_IDLE, done_reg};
   // Offsets are dense words from zero up to the block size register
   wire rdHit = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= OFS_BLKSIZE;
   wire [31:0] rdMux = s_axi_araddr == OFS_MEMADDR ? {8'h00, memAddr_reg}
                     : s_axi_araddr == OFS_IOADDR  ? {24'h0, ioLow_reg}
                     : s_axi_araddr == OFS_COUNT   ? {16'h0, count_reg}
                     : s_axi_araddr == OFS_CTRL    ? ctlRead
                     : s_axi_araddr == OFS_STATUS  ? staRead
                     : s_axi_araddr == OFS_DSTADDR ? {8'h00, dstAddr_reg}
                     : s_axi_araddr == OFS_BLKSIZE ? {24'h0, blkSize_reg} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awOpen_reg <= 1'b1;
         wOpen_reg  <= 1'b1;
         arOpen_reg <= 1'b1;
         awAddr_reg <= '0;
         wData_reg  <= '0;
         wStrb_reg  <= '0;
         bValid_reg <= 1'b0;
         bResp_reg  <= RESP_OKAY;
         rValid_reg <= 1'b0;
         rResp_reg  <= RESP_OKAY;
         rData_reg  <= '0;
      end
      else
      begin
         if (awTake)
         begin
            awOpen_reg <= 1'b0;
            awAddr_reg <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
         end
         if (wTake)
         begin
            wOpen_reg <= 1'b0;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            bValid_reg <= 1'b1;
            bResp_reg  <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bDone)
         begin
            bValid_reg <= 1'b0;
            awOpen_reg <= 1'b1;
            wOpen_reg  <= 1'b1;
         end
         if (arTake)
         begin
            arOpen_reg <= 1'b0;
            rValid_reg <= 1'b1;
            rData_reg  <= rdMux;
            rResp_reg  <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rDone)
         begin
            rValid_reg <= 1'b0;
            arOpen_reg <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awOpen_reg;
   assign s_axi_wready  = wOpen_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign s_axi_arready = arOpen_reg;
   assign s_axi_rvalid  = rValid_reg;
   assign s_axi_rdata   = rData_reg;
   assign s_axi_rresp   = rResp_reg;
endmodule // dmasa_channel

//--- dmasa_pkg.sv
// Constants, register map and types for the short-address DMA channel.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register master.
// How it works
// - Cycle-steal releases the bus after every item.
// - Burst holds the bus to the end of the count unless a higher master asks.
// - External full-address runs move one item per request on 24-bit addresses.
// - Block runs move a block per request while no higher master asks, restore one address per block, may interrupt at the end.
// - I/O mode is set by this channel's mode field alone.
// - Serial receive-full copies I/O to memory; other sources copy memory to I/O.
// - I/O mode steps the 24-bit memory address after each item.
// - The I/O address is the 8-bit register under sixteen ones, never changed by transfers.
// - The 16-bit count drops once per item, or once per block in block runs; at zero enable clears and the run stops.
// - In I/O mode completion interrupts only when enabled.
// - A starting count of zero means 65,536 items.
// - Requests come from timers 0 to 3, serial empty/full and the external pin.
// - Idle mode is set by this channel's mode field alone.
// - Idle mode keeps both addresses fixed.
// - Idle-mode completion always interrupts.
// - I/O mode moves exactly one item per accepted request.
package dmasa_pkg;
   localparam int ADDR_W = 24;
   localparam int CNT_W  = 16;
   localparam int AXI_AW = 5;
   // Register byte offsets
   localparam logic [AXI_AW-1:0] OFS_MEMADDR = 5'h00;
   localparam logic [AXI_AW-1:0] OFS_IOADDR  = 5'h04;
   localparam logic [AXI_AW-1:0] OFS_COUNT   = 5'h08;
   localparam logic [AXI_AW-1:0] OFS_CTRL    = 5'h0c;
   localparam logic [AXI_AW-1:0] OFS_STATUS  = 5'h10;
   localparam logic [AXI_AW-1:0] OFS_DSTADDR = 5'h14;
   localparam logic [AXI_AW-1:0] OFS_BLKSIZE = 5'h18;
   // Control and status field positions
   localparam int CTL_EN     = 0;
   localparam int CTL_IRQEN  = 1;
   localparam int CTL_WORD   = 2;
   localparam int CTL_DEC    = 3;
   localparam int CTL_BLKSRC = 4;
   localparam int CTL_MODE   = 8;
   localparam int CTL_SRC    = 12;
   localparam int CTL_DSTST  = 16;
   localparam int STA_DONE   = 0;
   localparam int STA_BUSY   = 1;
   // Modes
   localparam logic [2:0] MODE_IO    = 3'h0;
   localparam logic [2:0] MODE_IDLE  = 3'h1;
   localparam logic [2:0] MODE_EXT   = 3'h2;
   localparam logic [2:0] MODE_BURST = 3'h3;
   localparam logic [2:0] MODE_STEAL = 3'h4;
   localparam logic [2:0] MODE_BLOCK = 3'h5;
   // Request sources
   localparam logic [2:0] SRC_RXFULL  = 3'h5;
   localparam logic [2:0] SRC_TXEMPTY = 3'h4;
   localparam logic [2:0] SRC_EXTEDGE = 3'h6;
   localparam logic [2:0] SRC_EXTLVL  = 3'h7;
   // Destination step codes
   localparam logic [1:0] STEP_FIX = 2'h0;
   localparam logic [1:0] STEP_INC = 2'h1;
   localparam logic [1:0] STEP_DEC = 2'h2;
   localparam logic [15:0] IO_HIGH_ONES = 16'hffff;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [7:0]  BLK_ONE = 8'h01;
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_GAP} dmasa_state_t;
endpackage

//--- dmasa_sync.sv
// Two-flop synchroniser for the external request pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module dmasa_sync
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin and synchronised level
   input  wire logic pinIn,
   output logic      levelOut
);
   logic stage1_reg;
   logic stage2_reg;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1_reg <= 1'b1;
         stage2_reg <= 1'b1;
      end
      else
      begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
      end
   end
   assign levelOut = stage2_reg;
endmodule // dmasa_sync

//--- dmasa_checker.sv
// Port-level assertions for the short-address DMA channel.
// Assumes it is bound into dmasa_channel with one clock and synchronous rst.
`timescale 1ns/1ps
module dmasa_checker
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   // System bus side
   input wire logic        busReq,
   input wire logic        busGrant,
   input wire logic        higherMasterReq,
   input wire logic        xferValid,
   input wire logic [23:0] xferSrc,
   input wire logic [23:0] xferDst,
   input wire logic        xferWord,
   input wire logic        xferDone,
   input wire logic        cpuIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_grant_first: assert property ($rose(xferValid) |-> $past(busGrant) && busReq)
      else $error("item started without a grant");
   a_item_held: assert property (xferValid && !xferDone |=> xferValid && $stable(xferSrc) && $stable(xferDst)
      && $stable(xferWord))
      else $error("item changed before it finished");
   a_item_ends: assert property (xferValid && xferDone |=> !xferValid)
      else $error("item outlived its done");
   a_xfer_owns_bus: assert property (xferValid |-> busReq)
      else $error("item without bus request");
   a_higher_yields: assert property (xferValid && xferDone && higherMasterReq |=> !busReq)
      else $error("bus kept against a higher master");
   a_irq_at_end: assert property ($rose(cpuIrq) |-> $past(xferValid && xferDone))
      else $error("interrupt not tied to a finished item");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   c_yield: cover property (xferValid && xferDone && higherMasterReq);
   c_irq: cover property ($rose(cpuIrq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // dmasa_checker

bind dmasa_channel dmasa_checker dmasa_checker_inst (.*);

//--- dmasa_bus_model.sv
// Behavioural arbiter and system bus facing the channel.
// Assumes busReq stays high while the channel wants the bus; delays are random.
`timescale 1ns/1ps
module dmasa_bus_model
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Channel side
   input  wire logic busReq,
   input  wire logic xferValid,
   output logic      busGrant,
   output logic      xferDone
);
   // Grant is withdrawn as soon as the request drops, so a held bus shows up
   always @(posedge clk)
   begin
      if (rst)
      begin
         busGrant <= 1'b0;
         xferDone <= 1'b0;
      end
      else
      begin
         busGrant <= busReq && (busGrant || $urandom_range(2) == 0);
         xferDone <= xferValid && !xferDone && $urandom_range(2) == 0;
      end
   end
endmodule // dmasa_bus_model

//--- tb_dma_short_address_channel.sv
// Self-checking bench for the short-address DMA channel.
// Assumes the package and all design files compile first.
`timescale 1ns/1ps
module tb_dma_short_address_channel;
   import dmasa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, timerMatchA = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, prevReq, eWord;
   logic serialTxEmpty = 1'b0, serialRxFull = 1'b0, extReqN = 1'b1, higherMasterReq = 1'b0;
   logic busReq, busGrant, xferValid, xferWord, xferDone, cpuIrq;
   logic [ADDR_W-1:0] xferSrc, xferDst, eSrc, eDst, sStep, dStep;
   int n_fail = 0, compares = 0, items = 0, falls = 0;
   always #25 clk = ~clk;
   dmasa_channel dmasa_channel_inst (.*);
   dmasa_bus_model dmasa_bus_model_inst (.*);
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function logic [23:0] stepOf(input logic [2:0] m, input logic [2:0] f);
      logic [23:0] d;
      d = f[1] ? 24'h2 : 24'h1;
      if (m == MODE_IDLE) return 24'h0;
      return f[2] ? -d : d;
   endfunction
   function logic irqExp(input logic [2:0] m, input logic ie, input logic [15:0] left);
      return left == 16'h0 && (m == MODE_IDLE || ie);
   endfunction
   // Each finished item against the running expectation
   always @(posedge clk)
   begin
      prevReq <= busReq;
      if (prevReq === 1'b1 && busReq === 1'b0) falls <= falls + 1;
      if (xferValid === 1'b1 && xferDone === 1'b1)
      begin
         chk({7'h0, xferWord, xferSrc}, {7'h0, eWord, eSrc});
         chk({8'h00, xferDst}, {8'h00, eDst});
         eSrc <= eSrc + sStep;
         eDst <= eDst + dStep;
         items <= items + 1;
      end
   end
   task wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         t++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      chk({31'h0, t < 50}, 32'h1);
   endtask
   task rd(input logic [AXI_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      chk({31'h0, t < 50}, 32'h1);
   endtask
   task pulse(input logic [2:0] s);
      @(posedge clk);
      if (s < 3'h4) timerMatchA[s[1:0]] <= 1'b1;
      else if (s == SRC_TXEMPTY) serialTxEmpty <= 1'b1;
      else if (s == SRC_RXFULL) serialRxFull <= 1'b1;
      else extReqN <= 1'b0;
      @(posedge clk);
      timerMatchA <= 4'h0;
      serialTxEmpty <= 1'b0;
      serialRxFull <= 1'b0;
      extReqN <= 1'b1;
   endtask
   task wt(input int n);
      int t;
      t = 0;
      while (items != n && t < 500)
      begin
         @(posedge clk);
         t++;
      end
      chk({31'h0, t < 500}, 32'h1);
   endtask
   // f: irq enable, word, decrement; nq 0 = auto run
   task run(input logic [2:0] m, input logic [2:0] s, input logic [2:0] f, input logic [15:0] c, input int nq,
      input logic hm);
      logic [23:0] mem, io, st;
      logic [15:0] left;
      logic [31:0] ctrl;
      int base, ni;
      mem = 24'($urandom);
      io = {IO_HIGH_ONES, 8'($urandom)};
      st = stepOf(m, f);
      eWord = f[1];
      base = items;
      ni = (nq == 0) ? int'(c) : nq;
      ctrl = (32'(s) << CTL_SRC) | (32'(m) << CTL_MODE) | (32'(f) << CTL_IRQEN) | 32'h1;
      wr(OFS_MEMADDR, {8'h00, mem}, RESP_OKAY);
      wr(OFS_IOADDR, {24'h0, io[7:0]}, RESP_OKAY);
      wr(OFS_DSTADDR, {8'h00, io}, RESP_OKAY);
      wr(OFS_COUNT, {16'h0, c}, RESP_OKAY);
      wr(OFS_STATUS, 32'h1, RESP_OKAY);
      if (s == SRC_RXFULL && m < MODE_EXT)
      begin
         eSrc = io;
         eDst = mem;
         sStep = 24'h0;
         dStep = st;
      end
      else
      begin
         eSrc = mem;
         eDst = io;
         sStep = st;
         dStep = 24'h0;
      end
      higherMasterReq <= hm;
      falls = 0;
      wr(OFS_CTRL, ctrl, RESP_OKAY);
      for (int k = 0; k < nq; k++)
      begin
         pulse(s);
         wt(base + k + 1);
      end
      wt(base + ni);
      repeat (4) @(posedge clk);
      left = c - 16'(ni);
      rd(OFS_COUNT, {16'h0, left}, RESP_OKAY);
      rd(OFS_CTRL, ctrl & ~{31'h0, left == 16'h0}, RESP_OKAY);
      chk({31'h0, cpuIrq}, {31'h0, irqExp(m, f[0], left)});
      if (nq == 0) chk(32'(falls), (hm || m == MODE_STEAL) ? 32'(c) : 32'h1);
      higherMasterReq <= 1'b0;
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
   endtask
   initial
   begin
      int r;
      void'($urandom(82998));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wr(5'h1c, 32'hffffffff, RESP_SLVERR);
      rd(5'h1c, 32'h0, RESP_SLVERR);
      run(MODE_IO, SRC_TXEMPTY, 3'b001, 16'h3, 3, 1'b0);
      for (int i = 0; i < 4; i++) run(MODE_IO, 3'(i), 3'b001, 16'h1, 1, 1'b0);
      run(MODE_IO, SRC_RXFULL, 3'b110, 16'h2, 2, 1'b0);
      run(MODE_IDLE, 3'($urandom_range(3)), 3'b000, 16'h2, 2, 1'b0);
      run(MODE_IDLE, SRC_EXTLVL, 3'b010, 16'h1, 1, 1'b0);
      run(MODE_IO, SRC_EXTEDGE, 3'b001, 16'h0, 2, 1'b0);
      run(MODE_EXT, SRC_EXTEDGE, 3'b001, 16'h2, 2, 1'b0);
      run(MODE_BLOCK, 3'h1, 3'b001, 16'h2, 2, 1'b0);
      run(MODE_BURST, 3'h0, 3'b001, 16'h3, 0, 1'b0);
      run(MODE_STEAL, 3'h0, 3'b010, 16'h3, 0, 1'b0);
      run(MODE_BURST, 3'h0, 3'b000, 16'h3, 0, 1'b1);
      r = items;
      pulse(SRC_TXEMPTY);
      repeat (10) @(posedge clk);
      chk(32'(items), 32'(r));
      close_out();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      close_out();
   end
endmodule // tb_dma_short_address_channel
